/* File: core/trip_pkg.sv */
// Purpose: constants for the fault trip supervisor and fault history log
// Assumes: 20 MHz hclk, AHB-Lite register access
// Notes:   error codes are the displayed decimal numbers
//
// Functional notes
// - snapshot operating data at fault instant
// - history holds present plus five previous
// - new fault shifts log, writes entry one
// - entry one newest, entry six oldest
// - trip shows error code automatically
// - over-current codes by motion state, output off
// - overload trip reports overload code
// - braking duty over limit trips, code six
// - bus over-voltage trips
// - memory fault trips, memory code
// - bus under-voltage trips, under-voltage code
// - current sensing failure trips, code ten
// - processor malfunction trips, code eleven
// - external trip input trips, code twelve
// - run at power-up with guard trips
// - ground fault at power-up trips
// - input over-voltage tested after stop interval
// - thermal sensor disconnected reports code nineteen
// - module over-temperature trips, code twenty-one
// - reset rejected within hold-off after trip
package trip_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] snap_off   = 8'h08;
  localparam logic [7:0] log_off    = 8'h10;
  localparam logic [7:0] log_last   = 8'h24;
  localparam int         ctrl_reset_bit = 0;
  localparam int         ctrl_guard_bit = 1;
  localparam int         ctrl_duty_lsb  = 8;
  localparam logic [7:0] duty_reset     = 8'hFF;
  // guard on from reset, so a run command held through power-up is caught
  localparam logic       guard_reset    = 1'b1;
  localparam logic [1:0] settle_cnt     = 2'h3;
  // ------------------------------------------------------------
  // error codes
  // ------------------------------------------------------------
  localparam logic [7:0] code_none  = 8'h00;
  localparam logic [7:0] code_oc_cs = 8'h01;
  localparam logic [7:0] code_oc_dc = 8'h02;
  localparam logic [7:0] code_oc_ac = 8'h03;
  localparam logic [7:0] code_oc_ot = 8'h04;
  localparam logic [7:0] code_ol    = 8'h05;
  localparam logic [7:0] code_brk   = 8'h06;
  localparam logic [7:0] code_ov    = 8'h07;
  localparam logic [7:0] code_mem   = 8'h08;
  localparam logic [7:0] code_uv    = 8'h09;
  localparam logic [7:0] code_cur   = 8'h0A;
  localparam logic [7:0] code_cpu   = 8'h0B;
  localparam logic [7:0] code_ext   = 8'h0C;
  localparam logic [7:0] code_guard = 8'h0D;
  localparam logic [7:0] code_gnd   = 8'h0E;
  localparam logic [7:0] code_inov  = 8'h0F;
  localparam logic [7:0] code_tsens = 8'h13;
  localparam logic [7:0] code_therm = 8'h15;
  // motion states
  localparam logic [1:0] mot_const = 2'h0;
  localparam logic [1:0] mot_decel = 2'h1;
  localparam logic [1:0] mot_accel = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint clk_hz        = 20000000;
  localparam longint holdoff_s     = 10;
  localparam longint stop_test_s   = 100;
  localparam longint holdoff_cyc   = holdoff_s * clk_hz;
  localparam longint stop_test_cyc = stop_test_s * clk_hz;
  localparam int     depth         = 6;
endpackage

/* File: core/trip_fault_logger.sv */
// Purpose: fault trip supervisor with six-deep shifting history
// Assumes: fault detector inputs are asynchronous levels
// Notes:   a log word is {motion, snapshot[15:0], code}
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module trip_fault_logger
  import trip_pkg::*;
#(
  parameter longint holdoff_cycles   = holdoff_cyc,
  parameter longint stop_test_cycles = stop_test_cyc
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // fault detectors (asynchronous)
  input  wire logic        overcurrent,
  input  wire logic [1:0]  motion_state,
  input  wire logic        overload,
  input  wire logic [7:0]  brake_duty,
  input  wire logic        bus_overvolt,
  input  wire logic        mem_fault,
  input  wire logic        bus_undervolt,
  input  wire logic        cur_sense_fail,
  input  wire logic        cpu_fault,
  input  wire logic        external_trip_input,
  input  wire logic        run_cmd,
  input  wire logic        ground_fault,
  input  wire logic        input_overvolt,
  input  wire logic        therm_open,
  input  wire logic        overtemp,
  input  wire logic [15:0] oper_data,
  // power stage and display
  output logic             output_off,
  output logic      [7:0]  display_code,
  output logic             tripped
);
  localparam int nsync = 19;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [nsync-1:0] raw_in, s1_ff, s2_ff;
  logic [1:0]       mot1_ff, mot2_ff;
  logic [7:0]       duty1_ff, duty2_ff;
  logic [15:0]      op1_ff, op2_ff;
  assign raw_in = {run_cmd, overcurrent, overload, bus_overvolt, mem_fault, bus_undervolt,
                   cur_sense_fail, cpu_fault, external_trip_input, ground_fault,
                   input_overvolt, therm_open, overtemp, 6'h00};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      mot1_ff  <= 2'h0;
      mot2_ff  <= 2'h0;
      duty1_ff <= 8'h00;
      duty2_ff <= 8'h00;
      op1_ff   <= 16'h0000;
      op2_ff   <= 16'h0000;
    end else begin
      s1_ff    <= raw_in;
      s2_ff    <= s1_ff;
      mot1_ff  <= motion_state;
      mot2_ff  <= mot1_ff;
      duty1_ff <= brake_duty;
      duty2_ff <= duty1_ff;
      op1_ff   <= oper_data;
      op2_ff   <= op1_ff;
    end
  end
  logic run_s, oc_s, ol_s, ov_s, mem_s, uv_s, cur_s, cpu_s, ext_s, gnd_s, inov_s;
  logic tsens_s, therm_s;
  assign {run_s, oc_s, ol_s, ov_s, mem_s, uv_s, cur_s, cpu_s, ext_s, gnd_s,
          inov_s, tsens_s, therm_s} = s2_ff[nsync-1:6];

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        ctrl_reset_ff, guard_ff;
  logic [7:0]  duty_lim_ff;
  logic        wr_ph_ff, rd_ph_ff;
  logic [7:0]  addr_ff;
  logic        rst_req;
  logic [25:0] log_ff [depth];
  logic [15:0] snap_ff;
  logic [7:0]  code_ff;
  logic        trip_ff, holdoff_ff, powerup_ff, stop_ok_ff;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ctrl_off) v = {16'h0000, duty_lim_ff, 6'h00, guard_ff, 1'b0};
    else if (a == status_off) v = {20'h00000, holdoff_ff, stop_ok_ff, 1'b0, trip_ff, code_ff};
    else if (a == snap_off) v = {16'h0000, snap_ff};
    else if (a >= log_off && a <= log_last && a[1:0] == 2'h0)
      v = {6'h00, log_ff[3'((a - log_off) >> 2)]};
    return v;
  endfunction

  wire addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff  <= 8'h00;
    end else if (hready) begin
      wr_ph_ff <= addr_ok && hwrite;
      rd_ph_ff <= addr_ok && !hwrite;
      addr_ff  <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_ff      <= guard_reset;
      duty_lim_ff   <= duty_reset;
      ctrl_reset_ff <= 1'b0;
    end else begin
      ctrl_reset_ff <= 1'b0;
      if (wr_ph_ff && addr_ff == ctrl_off) begin
        guard_ff      <= hwdata[ctrl_guard_bit];
        duty_lim_ff   <= hwdata[ctrl_duty_lsb +: 8];
        ctrl_reset_ff <= hwdata[ctrl_reset_bit];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite) hrdata <= rd_mux(haddr[7:0]);
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rst_req   = ctrl_reset_ff;

  // ------------------------------------------------------------
  // fault priority encode
  // ------------------------------------------------------------
  logic [7:0] nxt_code;
  always_comb begin
    nxt_code = code_none;
    if (cpu_s) nxt_code = code_cpu;
    else if (mem_s) nxt_code = code_mem;
    else if (gnd_s && powerup_ff) nxt_code = code_gnd;
    else if (run_s && guard_ff && powerup_ff) nxt_code = code_guard;
    else if (oc_s) begin
      case (mot2_ff)
        mot_const: nxt_code = code_oc_cs;
        mot_decel: nxt_code = code_oc_dc;
        mot_accel: nxt_code = code_oc_ac;
        default:   nxt_code = code_oc_ot;
      endcase
    end
    else if (cur_s) nxt_code = code_cur;
    else if (ov_s) nxt_code = code_ov;
    else if (uv_s) nxt_code = code_uv;
    else if (ol_s) nxt_code = code_ol;
    else if (duty2_ff > duty_lim_ff) nxt_code = code_brk;
    else if (ext_s) nxt_code = code_ext;
    else if (inov_s && stop_ok_ff) nxt_code = code_inov;
    else if (tsens_s) nxt_code = code_tsens;
    else if (therm_s) nxt_code = code_therm;
  end
  wire new_trip = !trip_ff && nxt_code != code_none;

  // ------------------------------------------------------------
  // power-up window and stop timer
  // ------------------------------------------------------------
  logic [31:0] stop_cnt_ff;
  logic [1:0]  pu_cnt_ff;
  // synchronisers hold zeros from reset; wait until real levels reach s2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pu_cnt_ff <= 2'h0;
    else if (pu_cnt_ff != settle_cnt) pu_cnt_ff <= pu_cnt_ff + 2'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) powerup_ff <= 1'b1;
    else if (powerup_ff && pu_cnt_ff == settle_cnt && s2_ff == s1_ff) powerup_ff <= 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_cnt_ff <= 32'h0000_0000;
      stop_ok_ff  <= 1'b0;
    end else if (run_s) begin
      stop_cnt_ff <= 32'h0000_0000;
      stop_ok_ff  <= 1'b0;
    end else if (stop_cnt_ff < 32'(stop_test_cycles - 1)) begin
      stop_cnt_ff <= stop_cnt_ff + 32'h1;
    end else begin
      stop_ok_ff  <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // trip latch and reset hold-off
  // ------------------------------------------------------------
  logic [31:0] hold_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_ff <= 1'b0;
      code_ff <= code_none;
    end else if (new_trip) begin
      trip_ff <= 1'b1;
      code_ff <= nxt_code;
    end else if (trip_ff && rst_req && !holdoff_ff) begin
      trip_ff <= 1'b0;
      code_ff <= code_none;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_ff <= 32'h0000_0000;
      holdoff_ff  <= 1'b0;
    end else if (new_trip) begin
      hold_cnt_ff <= 32'h0000_0000;
      holdoff_ff  <= 1'b1;
    end else if (holdoff_ff) begin
      if (hold_cnt_ff >= 32'(holdoff_cycles - 2)) holdoff_ff <= 1'b0;
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_off   <= 1'b0;
      display_code <= code_none;
      tripped      <= 1'b0;
    end else begin
      output_off   <= trip_ff || new_trip;
      display_code <= new_trip ? nxt_code : code_ff;
      tripped      <= trip_ff || new_trip;
    end
  end

  // ------------------------------------------------------------
  // fault history
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) snap_ff <= 16'h0000;
    else if (new_trip) snap_ff <= op2_ff;
  end
  genvar gi;
  generate
    for (gi = 0; gi < depth; gi++) begin : g_log
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) log_ff[gi] <= 26'h0;
        else if (new_trip) begin
          if (gi == 0) log_ff[gi] <= {mot2_ff, op2_ff, nxt_code};
          else log_ff[gi] <= log_ff[gi-1];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_log_shift: assert property (@(posedge hclk) disable iff (!hresetn)
    new_trip |=> log_ff[1] == $past(log_ff[0]) && log_ff[0][7:0] == $past(nxt_code))
    else $error("log did not shift on trip");
  a_code_show: assert property (@(posedge hclk) disable iff (!hresetn)
    new_trip |=> display_code == $past(nxt_code) && output_off)
    else $error("code not shown on trip");
  a_trip_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    trip_ff && (!rst_req || holdoff_ff) |=> trip_ff && $stable(code_ff))
    else $error("trip dropped without accepted reset");
  a_early_rst: assert property (@(posedge hclk) disable iff (!hresetn)
    new_trip |=> holdoff_ff)
    else $error("hold-off not started");
  a_log_age: assert property (@(posedge hclk) disable iff (!hresetn)
    new_trip |=> log_ff[depth-1] == $past(log_ff[depth-2]))
    else $error("oldest entry not shifted");
  a_out_off: assert property (@(posedge hclk) disable iff (!hresetn)
    trip_ff |=> output_off && tripped)
    else $error("output not off while tripped");
endmodule

/* File: tb/power_stage_model.sv */
// Purpose: power stage and keypad model facing the trip logger
// Assumes: bench sets the fault levels
// Notes:   keypad shows a code only while the output is off
`timescale 1ns/1ps
module power_stage_model (
  // bench side
  input  wire logic        hclk,
  input  wire logic [11:0] fault_req,
  // logger side
  input  wire logic        output_off,
  input  wire logic [7:0]  display_code,
  output logic      [11:0] det,
  output logic      [7:0]  shown_code
);
  assign det = fault_req;
  // display refresh lags a cycle, so the code must stand while tripped
  always_ff @(posedge hclk) begin
    shown_code <= output_off ? display_code : 8'h00;
  end
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the trip fault logger
// Assumes: shortened hold-off and stop interval
// Notes:   history compared with a queue model
`timescale 1ns/1ps
module tb_top;
  import trip_pkg::*;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  localparam int hold_c = 20;
  localparam int stop_c = 50;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, output_off, tripped, run_c;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, motion_state;
  logic [7:0]  brake_duty, display_code, shown_code, lim;
  logic [15:0] oper_data;
  logic [11:0] fault_req, det;
  logic [31:0] model_log[$];
  int          fail_count, n_tests, seed;
  logic [7:0]  codes[10] = '{code_ol, code_ov, code_mem, code_uv, code_cur, code_cpu,
                             code_ext, code_inov, code_tsens, code_therm};
  int          bits[10]  = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11};
  logic [7:0]  occ[4]    = '{code_oc_cs, code_oc_dc, code_oc_ac, code_oc_ot};

  trip_fault_logger #(.holdoff_cycles(hold_c), .stop_test_cycles(stop_c)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overcurrent(det[0]), .overload(det[1]),
    .motion_state(motion_state), .brake_duty(brake_duty), .bus_overvolt(det[2]),
    .mem_fault(det[3]), .bus_undervolt(det[4]), .cur_sense_fail(det[5]),
    .cpu_fault(det[6]), .external_trip_input(det[7]), .run_cmd(run_c),
    .ground_fault(det[8]), .input_overvolt(det[9]), .therm_open(det[10]),
    .overtemp(det[11]), .oper_data(oper_data), .output_off(output_off),
    .display_code(display_code), .tripped(tripped));
  power_stage_model u_stage (.hclk(hclk), .fault_req(fault_req), .output_off(output_off),
    .display_code(display_code), .det(det), .shown_code(shown_code));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    results();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) timeout();
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic trip(input int b, input logic [7:0] c, input logic [1:0] m);
    logic [15:0] od;
    int          i;
    od = 16'($random(seed));
    if (b != 8) begin
      cyc(stop_c + 10);
      motion_state <= m;
      oper_data    <= od;
      cyc(4);
      if (b < 0) brake_duty <= lim + 8'h01;
      else fault_req[b] <= 1'b1;
    end else begin
      m  = motion_state;
      od = oper_data;
    end
    i = 0;
    while (output_off !== 1'b1 && i < 20) begin
      @(posedge hclk);
      i++;
    end
    if (i >= 20) timeout();
    cyc(2);
    check("keypad code", shown_code, c);
    model_log.push_front({6'h00, m, od, c});
    if (model_log.size() > depth) model_log.pop_back();
    bus(ctrl_off, 1'b1, {16'h0000, lim, 8'h01});
    cyc(2);
    check("early reset", {tripped, output_off, display_code}, {2'b11, c});
    bus(status_off, 1'b0, 32'h0);
    check("status", {rd[11], rd[8:0]}, {2'b11, c});
    for (i = 0; i < depth; i++) begin
      bus(log_off + 8'(4 * i), 1'b0, 32'h0);
      check("log entry", rd, (i < model_log.size()) ? model_log[i] : 32'h0);
    end
    fault_req  <= 12'h000;
    brake_duty <= 8'h00;
    cyc(hold_c + 5);
    bus(ctrl_off, 1'b1, {16'h0000, lim, 8'h01});
    cyc(4);
    check("cleared", {tripped, output_off}, 2'b00);
    $display("trip test code %h done", c);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    int j;
    seed         = 32'h89d1;
    hresetn      = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hwdata       = 32'h0;
    run_c        = 1'b0;
    motion_state = 2'h0;
    oper_data    = 16'($random(seed));
    brake_duty   = 8'h00;
    fault_req    = 12'h100;
    lim          = duty_reset;
    cyc(4);
    hresetn <= 1'b1;
    trip(8, code_gnd, 2'h0);
    for (j = 0; j < 4; j++) trip(0, occ[j], 2'(j));
    for (j = 0; j < 10; j++) trip(bits[j], codes[j], 2'($random(seed)));
    bus(32'h0000_0040, 1'b1, 32'hFFFF_FFFF);
    bus(32'h0000_0040, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    check("response", hresp, 1'b0);
    lim = 8'h40;
    bus(ctrl_off, 1'b1, {16'h0000, lim, 8'h00});
    bus(ctrl_off, 1'b0, 32'h0);
    check("duty limit", rd[15:8], lim);
    brake_duty <= lim;
    cyc(10);
    check("duty at limit", tripped, 1'b0);
    trip(-1, code_brk, 2'h1);
    $display("bus and duty tests done");
    run_c   <= 1'b1;
    hresetn <= 1'b0;
    cyc(4);
    check("in reset", {tripped, output_off, display_code}, 10'h000);
    model_log.delete();
    hresetn <= 1'b1;
    trip(8, code_guard, 2'h0);
    run_c <= 1'b0;
    results();
  end
endmodule
